// ==== inc/mbsci_pkg.sv ====
package mbsci_pkg;

	// accepted function codes
	localparam logic [7:0] FC_READ_COILS  = 8'h01;
	localparam logic [7:0] FC_READ_DISC   = 8'h02;
	localparam logic [7:0] FC_READ_HOLD   = 8'h03;
	localparam logic [7:0] FC_READ_INPUT  = 8'h04;
	localparam logic [7:0] FC_WRITE_COIL  = 8'h05;
	localparam logic [7:0] FC_WRITE_REG   = 8'h06;
	localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
	localparam logic [7:0] FC_WRITE_REGS  = 8'h10;

	// exception reply
	localparam logic [7:0] EXC_FLAG         = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_NONE         = 8'h00;

	// zero-based protocol addresses of the tables
	localparam logic [15:0] ANA_BASE = 16'h0FA0;
	localparam logic [15:0] PUL_BASE = 16'h1068;
	localparam logic [15:0] DIG_BASE = 16'h0FA0;

	localparam int ANA_CHANNELS = 64;
	localparam int DIG_CHANNELS = 64;
	localparam int PUL_CHANNELS = 32;
	localparam int PUL_WORDS    = 2 * PUL_CHANNELS;
	localparam int IDX_W        = 6;

	// single coil write value meaning on
	localparam logic [15:0] COIL_ON    = 16'hFF00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [63:0] DIG_RESET  = 64'h0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_XFER
	} mbsci_state_t;

	// true when qty is nonzero and start..start+qty-1 lies inside base..base+cnt-1
	function automatic logic in_span(
		input logic [15:0] start,
		input logic [15:0] qty,
		input logic [15:0] base,
		input int          cnt
	);
		logic [16:0] s;
		logic [16:0] e;
		logic [16:0] b;
		logic [16:0] lim;
		s   = {1'b0, start};
		e   = s + {1'b0, qty};
		b   = {1'b0, base};
		lim = b + 17'(cnt);
		return (qty != 16'h0000) && (s >= b) && (e <= lim);
	endfunction

endpackage

// ==== inc/mbsci_dec_if.sv ====
`timescale 1ns/1ns
interface mbsci_dec_if;
	logic [7:0]  func;
	logic [15:0] addr;
	logic [15:0] qty;
	logic        func_ok;
	logic        is_bit;
	logic        is_write;
	logic        single;
	logic        range_ok;
	logic        pulse;
	logic [15:0] base;
	logic [15:0] item_qty;

	modport dec (
		input  func,
		input  addr,
		input  qty,
		output func_ok,
		output is_bit,
		output is_write,
		output single,
		output range_ok,
		output pulse,
		output base,
		output item_qty
	);

	modport ctl (
		output func,
		output addr,
		output qty,
		input  func_ok,
		input  is_bit,
		input  is_write,
		input  single,
		input  range_ok,
		input  pulse,
		input  base,
		input  item_qty
	);
endinterface

// ==== rtl/mbsci_decode.sv ====
`timescale 1ns/1ns
module mbsci_decode
	import mbsci_pkg::*;
(
	mbsci_dec_if.dec d
);

	wire ana_hit;
	wire pul_hit;
	wire dig_hit;

	// function code class
	assign d.func_ok  = d.func inside {FC_READ_COILS, FC_READ_DISC,
		FC_READ_HOLD, FC_READ_INPUT, FC_WRITE_COIL, FC_WRITE_REG,
		FC_WRITE_COILS, FC_WRITE_REGS}; // R5
	assign d.is_bit   = d.func inside {FC_READ_COILS, FC_READ_DISC,
		FC_WRITE_COIL, FC_WRITE_COILS};
	assign d.is_write = d.func inside {FC_WRITE_COIL, FC_WRITE_REG,
		FC_WRITE_COILS, FC_WRITE_REGS};
	assign d.single   = (d.func == FC_WRITE_COIL) ||
		(d.func == FC_WRITE_REG);
	assign d.item_qty = d.single ? 16'h0001 : d.qty;

	// table spans
	assign ana_hit = in_span(d.addr, d.item_qty, ANA_BASE,
		ANA_CHANNELS); // R8
	assign pul_hit = in_span(d.addr, d.item_qty, PUL_BASE,
		PUL_WORDS); // R10
	assign dig_hit = in_span(d.addr, d.item_qty, DIG_BASE,
		DIG_CHANNELS); // R9

	assign d.range_ok = d.is_bit ? dig_hit : (ana_hit || pul_hit); // R7
	assign d.pulse    = !d.is_bit && pul_hit;
	assign d.base     = d.is_bit ? DIG_BASE :
		(pul_hit ? PUL_BASE : ANA_BASE);

endmodule

// ==== rtl/mbsci_slave.sv ====
`timescale 1ns/1ns
// Operation
// R1: function codes 01 and 02 are accepted and return the addressed bits.
// R2: function codes 03 and 04 are accepted and return the addressed words.
// R3: function codes 05 and 15 are accepted and update the addressed bits.
// R4: function codes 06 and 16 are accepted and store the supplied words.
// R5: every other function code, 07 to 24 among them, is rejected.
// R6: a rejected function code is answered with exception code 01.
// R7: an access outside the implemented map is answered with exception 02.
// R8: analog channel n sits at holding reference 44001 plus n minus one.
// R9: digital channel n sits at coil reference 04001 plus n minus one.
// R10: pulse channel n takes two registers from 44201, low word first.
// R11: an exception reply echoes the function code with bit 7 set and code.
module mbsci_slave
	import mbsci_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// request
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_func,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_qty,
	output logic             req_ready,
	// write data items
	input  wire logic        wr_valid,
	input  wire logic [15:0] wr_data,
	output logic             wr_ready,
	// read data items
	output logic             rd_valid,
	output logic [15:0]      rd_data,
	// reply
	output logic             rsp_valid,
	output logic [7:0]       rsp_func,
	output logic             rsp_exc,
	output logic [7:0]       rsp_code,
	// recorder side view of the channels
	input  wire logic [5:0]  usr_sel,
	output logic [15:0]      usr_analog,
	output logic [31:0]      usr_pulse,
	output logic [63:0]      usr_digital
);

	mbsci_dec_if dec_if ();

	mbsci_state_t state_q;
	logic [7:0]   func_q;
	logic [15:0]  addr_q;
	logic [15:0]  qty_q;
	logic [15:0]  cnt_q;
	logic         req_ready_q;
	logic         wr_ready_q;
	logic         rd_valid_q;
	logic [15:0]  rd_data_q;
	logic         rsp_valid_q;
	logic [7:0]   rsp_func_q;
	logic         rsp_exc_q;
	logic [7:0]   rsp_code_q;
	logic [15:0]  usr_analog_q;
	logic [31:0]  usr_pulse_q;
	logic [63:0]  dig_q;
	logic [15:0]  ana_mem [ANA_CHANNELS];
	logic [15:0]  pul_mem [PUL_WORDS];

	wire             in_xfer;
	wire             step;
	wire             last;
	wire             take_req;
	wire [15:0]      item_addr;
	wire [15:0]      offs;
	wire [IDX_W-1:0] idx;
	wire             bit_val;
	wire [15:0]      word_rd;
	wire             wr_bit;
	wire             wr_ana;
	wire             wr_pul;

	assign dec_if.func = func_q;
	assign dec_if.addr = addr_q;
	assign dec_if.qty  = qty_q;

	mbsci_decode u_decode (
		.d (dec_if.dec)
	);

	// item addressing
	assign take_req  = (state_q == ST_IDLE) && req_valid && req_ready_q;
	assign in_xfer   = (state_q == ST_XFER);
	assign item_addr = addr_q + cnt_q;
	assign offs      = item_addr - dec_if.base;
	assign idx       = offs[IDX_W-1:0];
	assign step      = in_xfer &&
		(dec_if.is_write ? (wr_valid && wr_ready_q) : 1'b1);
	assign last      = (cnt_q == (dec_if.item_qty - 16'h0001));
	assign bit_val   = dec_if.single ? (wr_data == COIL_ON) : wr_data[0];
	assign word_rd   = dec_if.is_bit ? {15'h0000, dig_q[idx]} :
		(dec_if.pulse ? pul_mem[idx] : ana_mem[idx]); // R1 R2
	assign wr_bit    = step && dec_if.is_write && dec_if.is_bit;
	assign wr_ana    = step && dec_if.is_write && !dec_if.is_bit &&
		!dec_if.pulse;
	assign wr_pul    = step && dec_if.is_write && !dec_if.is_bit &&
		dec_if.pulse;

	// request sequencing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= ST_IDLE;
			func_q      <= 8'h00;
			addr_q      <= 16'h0000;
			qty_q       <= 16'h0000;
			cnt_q       <= 16'h0000;
			req_ready_q <= 1'b1;
			wr_ready_q  <= 1'b0;
			rd_valid_q  <= 1'b0;
			rd_data_q   <= 16'h0000;
			rsp_valid_q <= 1'b0;
			rsp_func_q  <= 8'h00;
			rsp_exc_q   <= 1'b0;
			rsp_code_q  <= EXC_NONE;
		end else begin
			rd_valid_q  <= 1'b0;
			rsp_valid_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (take_req) begin
						func_q      <= req_func;
						addr_q      <= req_addr;
						qty_q       <= req_qty;
						req_ready_q <= 1'b0;
						state_q     <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					cnt_q <= 16'h0000;
					if (!dec_if.func_ok) begin
						rsp_valid_q <= 1'b1;
						rsp_exc_q   <= 1'b1;
						rsp_func_q  <= func_q | EXC_FLAG; // R11
						rsp_code_q  <= EXC_ILLEGAL_FUNC; // R6
						req_ready_q <= 1'b1;
						state_q     <= ST_IDLE;
					end else if (!dec_if.range_ok) begin
						rsp_valid_q <= 1'b1;
						rsp_exc_q   <= 1'b1;
						rsp_func_q  <= func_q | EXC_FLAG; // R11
						rsp_code_q  <= EXC_ILLEGAL_ADDR; // R7
						req_ready_q <= 1'b1;
						state_q     <= ST_IDLE;
					end else begin
						wr_ready_q <= dec_if.is_write;
						state_q    <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (step) begin
						cnt_q <= cnt_q + 16'h0001;
						if (!dec_if.is_write) begin
							rd_valid_q <= 1'b1; // R1 R2
							rd_data_q  <= word_rd;
						end
						if (last) begin
							rsp_valid_q <= 1'b1;
							rsp_exc_q   <= 1'b0;
							rsp_func_q  <= func_q;
							rsp_code_q  <= EXC_NONE;
							wr_ready_q  <= 1'b0;
							req_ready_q <= 1'b1;
							state_q     <= ST_IDLE;
						end
					end
				end
				default: begin
					req_ready_q <= 1'b1;
					wr_ready_q  <= 1'b0;
					state_q     <= ST_IDLE;
				end
			endcase
		end
	end

	// channel storage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dig_q <= DIG_RESET;
			for (int i = 0; i < ANA_CHANNELS; i++) begin
				ana_mem[i] <= WORD_RESET;
			end
			for (int i = 0; i < PUL_WORDS; i++) begin
				pul_mem[i] <= WORD_RESET;
			end
		end else begin
			if (wr_bit) begin
				dig_q[idx] <= bit_val; // R3 R9
			end
			if (wr_ana) begin
				ana_mem[idx] <= wr_data; // R4 R8
			end
			if (wr_pul) begin
				pul_mem[idx] <= wr_data; // R4 R10
			end
		end
	end

	// recorder side view, pulse pair low word first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			usr_analog_q <= WORD_RESET;
			usr_pulse_q  <= {WORD_RESET, WORD_RESET};
		end else begin
			usr_analog_q <= ana_mem[usr_sel];
			usr_pulse_q  <= {pul_mem[{usr_sel[4:0], 1'b1}],
				pul_mem[{usr_sel[4:0], 1'b0}]}; // R10
		end
	end

	assign req_ready   = req_ready_q;
	assign wr_ready    = wr_ready_q;
	assign rd_valid    = rd_valid_q;
	assign rd_data     = rd_data_q;
	assign rsp_valid   = rsp_valid_q;
	assign rsp_func    = rsp_func_q;
	assign rsp_exc     = rsp_exc_q;
	assign rsp_code    = rsp_code_q;
	assign usr_analog  = usr_analog_q;
	assign usr_pulse   = usr_pulse_q;
	assign usr_digital = dig_q;

	// checks
	a_bad_func_exc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == ST_CHECK && !dec_if.func_ok) |=>
		(rsp_valid && rsp_exc && rsp_code == EXC_ILLEGAL_FUNC)) // R6
		else $error("unaccepted function not answered with code 01");
	a_reject_codes: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == ST_CHECK && func_q >= 8'h07 && func_q <= 8'h18 &&
		func_q != FC_WRITE_COILS && func_q != FC_WRITE_REGS) |=>
		(rsp_valid && rsp_exc)) // R5
		else $error("unsupported function code accepted");
	a_addr_exc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == ST_CHECK && dec_if.func_ok && !dec_if.range_ok) |=>
		(rsp_valid && rsp_code == EXC_ILLEGAL_ADDR)) // R7
		else $error("out of map access not answered with code 02");
	a_exc_format: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rsp_valid && rsp_exc) |->
		(rsp_func == (func_q | EXC_FLAG) && rsp_code != EXC_NONE)) // R11
		else $error("exception reply malformed");
	a_bit_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(step && !dec_if.is_write && dec_if.is_bit) |=>
		(rd_valid && rd_data == {15'h0000, dig_q[$past(idx)]})) // R1
		else $error("bit read returned wrong channel");
	a_ana_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(step && !dec_if.is_write && !dec_if.is_bit && !dec_if.pulse) |=>
		(rd_valid && rd_data == ana_mem[$past(idx)])) // R2 R8
		else $error("analog read returned wrong word");
	a_coil_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_bit |=> (dig_q[$past(idx)] == $past(bit_val))) // R3 R9
		else $error("coil write not stored");
	a_word_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_ana |=> (ana_mem[$past(idx)] == $past(wr_data))) // R4
		else $error("register write not stored");
	a_pulse_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_pul && idx[0] == 1'b0) |=>
		(pul_mem[$past(idx)] == $past(wr_data))) // R10
		else $error("pulse low word not stored at even slot");

endmodule

// ==== bench/mbsci_master.sv ====
`timescale 1ns/1ns
module mbsci_master (
	// clock
	input  wire logic        core_clk,
	// request
	output logic             req_valid,
	output logic [7:0]       req_func,
	output logic [15:0]      req_addr,
	output logic [15:0]      req_qty,
	input  wire logic        req_ready,
	// write items
	output logic             wr_valid,
	output logic [15:0]      wr_data,
	input  wire logic        wr_ready,
	// read items and reply
	input  wire logic        rd_valid,
	input  wire logic [15:0] rd_data,
	input  wire logic        rsp_valid
);
	logic [15:0] rd_q[$];
	logic        done;

	initial begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_qty = 16'h0000;
		wr_valid = 1'b0;
		wr_data = 16'h0000;
		done = 1'b0;
	end

	// one request held until taken; items held until taken
	// released lines scrambled
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, q,
			input logic [15:0] wq[$]);
		int   i;
		logic taken;
		i = 0;
		taken = 1'b0;
		done = 1'b0;
		rd_q = {};
		@(negedge core_clk);
		req_valid = 1'b1;
		req_func = f;
		req_addr = a;
		req_qty = q;
		for (int w = 0; w < 50 && !taken; w++) begin
			taken = (req_ready === 1'b1);
			@(negedge core_clk);
		end
		req_valid = 1'b0;
		req_func = ~f;
		req_addr = ~a;
		req_qty = ~q;
		for (int n = 0; n < 300 && taken && !done; n++) begin
			if (rd_valid === 1'b1)
				rd_q.push_back(rd_data);
			if (rsp_valid === 1'b1) begin
				done = 1'b1;
				wr_valid = 1'b0;
			end else begin
				wr_valid = (wr_ready === 1'b1) && (i < wq.size());
				wr_data = wr_valid ? wq[i] : ~wr_data;
				if (wr_valid)
					i++;
				@(negedge core_clk);
			end
		end
		if (!done)
			wr_valid = 1'b0;
	endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	import mbsci_pkg::*;
	logic        core_clk;
	logic        rst_n;
	logic        req_valid;
	logic [7:0]  req_func;
	logic [15:0] req_addr;
	logic [15:0] req_qty;
	logic        req_ready;
	logic        wr_valid;
	logic [15:0] wr_data;
	logic        wr_ready;
	logic        rd_valid;
	logic [15:0] rd_data;
	logic        rsp_valid;
	logic [7:0]  rsp_func;
	logic        rsp_exc;
	logic [7:0]  rsp_code;
	logic [5:0]  usr_sel;
	logic [15:0] usr_analog;
	logic [31:0] usr_pulse;
	logic [63:0] usr_digital;
	logic [15:0] none[$];
	int          failures;
	int          tests_run;

	mbsci_slave uut (.core_clk(core_clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
		.req_qty(req_qty), .req_ready(req_ready), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
		.rsp_exc(rsp_exc), .rsp_code(rsp_code), .usr_sel(usr_sel),
		.usr_analog(usr_analog), .usr_pulse(usr_pulse),
		.usr_digital(usr_digital));

	mbsci_master mst (.core_clk(core_clk), .req_valid(req_valid),
		.req_func(req_func), .req_addr(req_addr), .req_qty(req_qty),
		.req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.rsp_valid(rsp_valid));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic complete_run;
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [63:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic run(input logic [7:0] f, input logic [15:0] a, q,
			input logic [15:0] wq[$]);
		mst.xfer(f, a, q, wq);
		if (mst.done !== 1'b1) begin
			failures++;
			complete_run();
		end
	endtask

	task automatic reply(input logic [7:0] f, input logic e,
			input logic [7:0] c);
		check("rsp_func", 64'(rsp_func), 64'(f));
		check("rsp_exc", 64'(rsp_exc), 64'(e));
		check("rsp_code", 64'(rsp_code), 64'(c));
	endtask

	task automatic pick(input logic [5:0] s);
		usr_sel = s;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic t_analog;
		run(FC_WRITE_REGS, ANA_BASE, 16'h0002, '{16'hA001, 16'hA002});
		reply(FC_WRITE_REGS, 1'b0, EXC_NONE);
		run(FC_WRITE_REG, ANA_BASE + 16'h003F, 16'h0001, '{16'h5A3C});
		reply(FC_WRITE_REG, 1'b0, EXC_NONE);
		pick(6'd63);
		check("ana64", 64'(usr_analog), 64'h5A3C);
		pick(6'd1);
		check("ana2", 64'(usr_analog), 64'hA002);
		run(FC_READ_HOLD, ANA_BASE, 16'h0002, none);
		check("rd03n", 64'(mst.rd_q.size()), 64'd2);
		check("rd03a", 64'(mst.rd_q[0]), 64'hA001);
		check("rd03b", 64'(mst.rd_q[1]), 64'hA002);
		reply(FC_READ_HOLD, 1'b0, EXC_NONE);
		run(FC_READ_INPUT, ANA_BASE + 16'h003F, 16'h0001, none);
		check("rd04", 64'(mst.rd_q[0]), 64'h5A3C);
		reply(FC_READ_INPUT, 1'b0, EXC_NONE);
	endtask

	task automatic t_pulse;
		run(FC_WRITE_REGS, PUL_BASE + 16'h003E, 16'h0002,
			'{16'h1111, 16'h2222});
		reply(FC_WRITE_REGS, 1'b0, EXC_NONE);
		pick(6'd31);
		check("pul32", 64'(usr_pulse), 64'h22221111);
		run(FC_READ_HOLD, PUL_BASE + 16'h003E, 16'h0002, none);
		check("rdpul", 64'({mst.rd_q[1], mst.rd_q[0]}), 64'h22221111);
		reply(FC_READ_HOLD, 1'b0, EXC_NONE);
	endtask

	task automatic t_coils;
		run(FC_WRITE_COIL, DIG_BASE, 16'h0001, '{COIL_ON});
		reply(FC_WRITE_COIL, 1'b0, EXC_NONE);
		run(FC_WRITE_COILS, DIG_BASE + 16'h003E, 16'h0002,
			'{16'h0001, 16'h0000});
		reply(FC_WRITE_COILS, 1'b0, EXC_NONE);
		check("dig", usr_digital, 64'h4000_0000_0000_0001);
		run(FC_READ_COILS, DIG_BASE + 16'h003E, 16'h0002, none);
		check("rd01n", 64'(mst.rd_q.size()), 64'd2);
		check("rd01", 64'({mst.rd_q[1], mst.rd_q[0]}), 64'h0000_0001);
		reply(FC_READ_COILS, 1'b0, EXC_NONE);
		run(FC_READ_DISC, DIG_BASE, 16'h0001, none);
		check("rd02", 64'(mst.rd_q[0]), 64'h0001);
		reply(FC_READ_DISC, 1'b0, EXC_NONE);
	endtask

	task automatic t_badfunc;
		for (int f = 8'h07; f <= 8'h18; f++) begin
			if (f != 8'h0F && f != 8'h10) begin
				run(8'(f), ANA_BASE, 16'h0001, none);
				reply(8'(f) | EXC_FLAG, 1'b1, EXC_ILLEGAL_FUNC);
			end
		end
	endtask

	task automatic t_badaddr;
		logic [7:0]  bf[7] = '{8'h03, 8'h01, 8'h01, 8'h04, 8'h03, 8'h03,
			8'h10};
		logic [15:0] ba[7] = '{16'h0FDF, 16'h0F9F, 16'h0FE0, 16'h1067,
			16'h10A7, 16'h0FA0, 16'h0FDF};
		logic [15:0] bq[7] = '{16'h0002, 16'h0001, 16'h0001, 16'h0002,
			16'h0002, 16'h0000, 16'h0002};
		for (int k = 0; k < 7; k++) begin
			run(bf[k], ba[k], bq[k], '{16'hDEAD, 16'hBEEF});
			reply(bf[k] | EXC_FLAG, 1'b1, EXC_ILLEGAL_ADDR);
		end
		pick(6'd63);
		check("nostore", 64'(usr_analog), 64'h5A3C);
	endtask

	// mid-run reset clears the digital map and analog channel 64
	task automatic t_reset;
		rst_n = 1'b0;
		@(negedge core_clk);
		check("rst2_ready", 64'(req_ready), 64'd1);
		check("rst2_dig", usr_digital, DIG_RESET);
		check("rst2_exc", 64'(rsp_exc), 64'd0);
		rst_n = 1'b1;
		pick(6'd63);
		check("rst2_ana", 64'(usr_analog), 64'(WORD_RESET));
		run(FC_READ_COILS, DIG_BASE, 16'h0001, none);
		check("rst2_rd", 64'(mst.rd_q[0]), 64'h0000);
		reply(FC_READ_COILS, 1'b0, EXC_NONE);
	endtask

	initial begin
		rst_n = 1'b0;
		usr_sel = 6'd0;
		failures = 0;
		tests_run = 0;
		repeat (12) @(negedge core_clk);
		check("rst_ready", 64'(req_ready), 64'd1);
		check("rst_dig", usr_digital, DIG_RESET);
		rst_n = 1'b1;
		t_analog();
		t_pulse();
		t_coils();
		t_badfunc();
		t_badaddr();
		t_reset();
		complete_run();
	end
endmodule
